// ### common/cfdiag_defines.svh
// Purpose: constants of the bus diagnostics block
// Assumes: included by bare name wherever needed
// Notes: offsets are byte addresses on the plain register port
`ifndef CFDIAG_DEFINES_SVH
`define CFDIAG_DEFINES_SVH

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define CFDIAG_ADDR_W 8
`define CFDIAG_DATA_W 32
`define CFDIAG_OFS_CNT 8'h00
`define CFDIAG_OFS_FLG 8'h04
`define CFDIAG_RESET_WORD 32'h0000_0000

// ----------------------------------------------------------------
// counter word layout
// ----------------------------------------------------------------
`define CFDIAG_CNT_W 8
`define CFDIAG_DTX_LSB 24
`define CFDIAG_DRX_LSB 16
`define CFDIAG_NTX_LSB 8
`define CFDIAG_NRX_LSB 0
`define CFDIAG_CNT_MAX 8'hff
`define CFDIAG_CNT_ONE 8'h01
`define CFDIAG_CNT_ZERO 8'h00

// ----------------------------------------------------------------
// flag word layout (flags live in bits 31..16)
// ----------------------------------------------------------------
`define CFDIAG_FLAG_W 16
`define CFDIAG_FLAG_BASE 16
`define CFDIAG_B_LENMM 31
`define CFDIAG_B_ESI 30
`define CFDIAG_B_DCRC 29
`define CFDIAG_B_DSTUFF 28
`define CFDIAG_B_DFORM 27
`define CFDIAG_B_RSVD_HI 26
`define CFDIAG_B_DBIT1 25
`define CFDIAG_B_DBIT0 24
`define CFDIAG_B_TXBO 23
`define CFDIAG_B_RSVD_LO 22
`define CFDIAG_B_NCRC 21
`define CFDIAG_B_NSTUFF 20
`define CFDIAG_B_NFORM 19
`define CFDIAG_B_NACK 18
`define CFDIAG_B_NBIT1 17
`define CFDIAG_B_NBIT0 16
`define CFDIAG_FLAG_ZERO 16'h0000
`define CFDIAG_GOOD_W 16
`define CFDIAG_GOOD_MAX 16'hffff
`define CFDIAG_GOOD_ONE 16'h0001
`define CFDIAG_GOOD_ZERO 16'h0000

// ----------------------------------------------------------------
// receive error state thresholds
// ----------------------------------------------------------------
`define CFDIAG_PASSIVE_ABOVE 8'h7f
`define CFDIAG_WARN_ABOVE 8'h5f
`define CFDIAG_WARN_BELOW 8'h80

`endif

// ### common/cfdiag_pkg.sv
// Purpose: types of the bus diagnostics block
// Assumes: cfdiag_defines.svh on the include path
// Notes: whole module state is one packed struct
`include "cfdiag_defines.svh"
`default_nettype none

package cfdiag_pkg;
	typedef struct packed {
		logic [`CFDIAG_CNT_W-1:0] dtx_cnt;
		logic [`CFDIAG_CNT_W-1:0] drx_cnt;
		logic [`CFDIAG_CNT_W-1:0] ntx_cnt;
		logic [`CFDIAG_CNT_W-1:0] nrx_cnt;
		logic [`CFDIAG_FLAG_W-1:0] flags;
		logic [`CFDIAG_GOOD_W-1:0] good_cnt;
		logic [`CFDIAG_DATA_W-1:0] rdata;
		logic passive;
		logic warning;
	} cfdiag_state_t;
endpackage : cfdiag_pkg

`default_nettype wire

// ### verilog/cfdiag_top.sv
// Purpose: bus quality diagnostics counters and sticky error flags
// Assumes: event inputs come from the protocol engine on clock_i
// Notes: counters and flags clear on any access of their word
//
// Notes on behaviour
// R01 - passive flag when receive count above 127
// R02 - warning flag when count 96 to 127
// R03 - data tx/rx counters in bits 31..16
// R04 - nominal tx/rx counters in bits 15..0
// R05 - counter plus one per error in phase
// R06 - diagnostic counters never count down
// R07 - reading counter word zeroes all four
// R08 - length mismatch sets bit 31
// R09 - received ESI set sets bit 30
// R10 - data phase CRC error sets bit 29
// R11 - data phase stuffing error sets bit 28
// R12 - data phase format error sets bit 27
// R13 - data phase recessive bit error bit 25
// R14 - bit 26 always reads zero
// R15 - flags sticky until next access
// R16 - read or write clears flag word
// R17 - only flag of offending phase set
// R18 - good frame counter counts, read clears
// R19 - recovery eleven recessive sets bit0 flag
// R20 - missing acknowledge sets nominal flag
// R21 - event with clearing access survives
// R22 - 8-bit counters saturate at maximum
`include "cfdiag_defines.svh"
`default_nettype none

module cfdiag_top
	import cfdiag_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// register port
	input wire logic [`CFDIAG_ADDR_W-1:0] addr_i,
	input wire logic [`CFDIAG_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [`CFDIAG_DATA_W-1:0] rdata_o,
	// error event qualifiers
	input wire logic err_data_phase_i,
	input wire logic err_tx_i,
	// error event pulses
	input wire logic crc_err_i,
	input wire logic stuff_err_i,
	input wire logic form_err_i,
	input wire logic recessive_bit_err_i,
	input wire logic dominant_bit_err_i,
	input wire logic ack_err_i,
	input wire logic length_mismatch_i,
	input wire logic esi_rx_i,
	input wire logic bus_off_event_i,
	input wire logic recovery_recessive_i,
	input wire logic good_frame_i,
	// standard receive error state
	input wire logic [`CFDIAG_CNT_W-1:0] standard_receive_error_count_i,
	output logic receiver_error_passive_flag_o,
	output logic receiver_warning_flag_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [`CFDIAG_CNT_W-1:0] cnt_next(
		input logic [`CFDIAG_CNT_W-1:0] v,
		input logic inc,
		input logic clr
	);
		logic [`CFDIAG_CNT_W-1:0] r;
		r = v;
		if (clr) begin
			r = `CFDIAG_CNT_ZERO;
		end
		// clear first, then count: a coinciding error is kept [R21]
		if (inc && r != `CFDIAG_CNT_MAX) begin // [R05] [R22]
			r = r + `CFDIAG_CNT_ONE;
		end
		return r; // no path subtracts [R06]
	endfunction : cnt_next

	cfdiag_state_t st_q;
	cfdiag_state_t st_d;

	logic unused_wdata;
	logic ph;
	logic ev_any;
	logic ev_dtx;
	logic ev_drx;
	logic ev_ntx;
	logic ev_nrx;
	logic sel_cnt;
	logic sel_flg;
	logic clr_cnt;
	logic clr_flg;
	logic [`CFDIAG_DATA_W-1:0] cnt_word;
	logic [`CFDIAG_DATA_W-1:0] flg_word;
	logic [`CFDIAG_DATA_W-1:0] flag_set;

	// writes only clear, their data is of no use
	assign unused_wdata = ^wdata_i;

	// ----------------------------------------------------------------
	// event decode
	// ----------------------------------------------------------------
	assign ph = err_data_phase_i;
	assign ev_any = crc_err_i | stuff_err_i | form_err_i |
		recessive_bit_err_i | dominant_bit_err_i | ack_err_i;
	// missing acknowledge is nominal transmit whatever the qualifiers
	assign ev_dtx = ev_any & ph & err_tx_i & ~ack_err_i;
	assign ev_drx = ev_any & ph & ~err_tx_i & ~ack_err_i;
	assign ev_ntx = ack_err_i | (ev_any & ~ph & err_tx_i);
	assign ev_nrx = ev_any & ~ph & ~err_tx_i & ~ack_err_i;

	always_comb begin
		flag_set = `CFDIAG_RESET_WORD;
		flag_set[`CFDIAG_B_LENMM] = length_mismatch_i; // [R08]
		flag_set[`CFDIAG_B_ESI] = esi_rx_i; // [R09]
		// data flags only when the error hit the data phase [R17]
		flag_set[`CFDIAG_B_DCRC] = crc_err_i & ph; // [R10]
		flag_set[`CFDIAG_B_DSTUFF] = stuff_err_i & ph; // [R11]
		flag_set[`CFDIAG_B_DFORM] = form_err_i & ph; // [R12]
		flag_set[`CFDIAG_B_DBIT1] = recessive_bit_err_i & ph; // [R13]
		flag_set[`CFDIAG_B_DBIT0] = dominant_bit_err_i & ph;
		flag_set[`CFDIAG_B_TXBO] = bus_off_event_i;
		flag_set[`CFDIAG_B_NCRC] = crc_err_i & ~ph; // [R17]
		flag_set[`CFDIAG_B_NSTUFF] = stuff_err_i & ~ph;
		flag_set[`CFDIAG_B_NFORM] = form_err_i & ~ph;
		flag_set[`CFDIAG_B_NACK] = ack_err_i; // [R20]
		flag_set[`CFDIAG_B_NBIT1] = recessive_bit_err_i & ~ph;
		// recovery runs at the nominal rate, so the nominal flag [R19]
		flag_set[`CFDIAG_B_NBIT0] = (dominant_bit_err_i & ~ph) |
			recovery_recessive_i;
		// reserved positions never set [R14]
		flag_set[`CFDIAG_B_RSVD_HI] = 1'b0;
		flag_set[`CFDIAG_B_RSVD_LO] = 1'b0;
	end

	// ----------------------------------------------------------------
	// register access
	// ----------------------------------------------------------------
	assign sel_cnt = addr_i == `CFDIAG_OFS_CNT;
	assign sel_flg = addr_i == `CFDIAG_OFS_FLG;
	// a write is the tail of a read-modify-write: it clears too
	assign clr_cnt = sel_cnt & (rd_i | wr_i); // [R07]
	assign clr_flg = sel_flg & (rd_i | wr_i); // [R16]

	assign cnt_word = {st_q.dtx_cnt, st_q.drx_cnt,
		st_q.ntx_cnt, st_q.nrx_cnt}; // [R03] [R04]
	assign flg_word = {st_q.flags, st_q.good_cnt};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.dtx_cnt = cnt_next(st_q.dtx_cnt, ev_dtx, clr_cnt);
		st_d.drx_cnt = cnt_next(st_q.drx_cnt, ev_drx, clr_cnt);
		st_d.ntx_cnt = cnt_next(st_q.ntx_cnt, ev_ntx, clr_cnt);
		st_d.nrx_cnt = cnt_next(st_q.nrx_cnt, ev_nrx, clr_cnt);
		// sticky, and a set in the clearing cycle wins [R15] [R21]
		st_d.flags = (clr_flg ? `CFDIAG_FLAG_ZERO : st_q.flags) |
			flag_set[`CFDIAG_DATA_W-1:`CFDIAG_FLAG_BASE];
		st_d.good_cnt = clr_flg ? `CFDIAG_GOOD_ZERO : st_q.good_cnt;
		// saturates so software never sees a false low count
		if (good_frame_i && st_d.good_cnt != `CFDIAG_GOOD_MAX) begin
			st_d.good_cnt = st_d.good_cnt + `CFDIAG_GOOD_ONE; // [R18]
		end
		// read data stands in the cycle after the strobe only
		st_d.rdata = `CFDIAG_RESET_WORD;
		if (rd_i && sel_cnt) begin
			st_d.rdata = cnt_word;
		end else if (rd_i && sel_flg) begin
			st_d.rdata = flg_word;
		end
		st_d.passive = standard_receive_error_count_i >
			`CFDIAG_PASSIVE_ABOVE; // [R01]
		st_d.warning = (standard_receive_error_count_i >
			`CFDIAG_WARN_ABOVE) && (standard_receive_error_count_i <
			`CFDIAG_WARN_BELOW); // [R02]
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_o = st_q.rdata;
	assign receiver_error_passive_flag_o = st_q.passive;
	assign receiver_warning_flag_o = st_q.warning;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	logic [`CFDIAG_CNT_W-1:0] sc;
	assign sc = standard_receive_error_count_i;

	passive_flag_a: assert property ( // [R01]
		##1 receiver_error_passive_flag_o ==
			($past(sc) > `CFDIAG_PASSIVE_ABOVE))
		else $error("passive flag disagrees with receive count");

	warning_flag_a: assert property ( // [R02]
		##1 receiver_warning_flag_o ==
			(($past(sc) > `CFDIAG_WARN_ABOVE) &&
			($past(sc) < `CFDIAG_WARN_BELOW)))
		else $error("warning flag disagrees with receive count");

	state_exclusive_a: assert property ( // [R02]
		!(receiver_warning_flag_o && receiver_error_passive_flag_o))
		else $error("warning and passive both set");

	cnt_read_layout_a: assert property ( // [R03]
		(rd_i && sel_cnt) |=> rdata_o == {$past(st_q.dtx_cnt),
			$past(st_q.drx_cnt), $past(st_q.ntx_cnt),
			$past(st_q.nrx_cnt)})
		else $error("counter word read layout wrong");

	nrx_increment_a: assert property ( // [R05]
		(ev_nrx && !clr_cnt && st_q.nrx_cnt != `CFDIAG_CNT_MAX) |=>
			st_q.nrx_cnt == $past(st_q.nrx_cnt) + `CFDIAG_CNT_ONE)
		else $error("nominal receive counter missed an error");

	dtx_increment_a: assert property ( // [R05]
		(ev_dtx && !clr_cnt && st_q.dtx_cnt != `CFDIAG_CNT_MAX) |=>
			st_q.dtx_cnt == $past(st_q.dtx_cnt) + `CFDIAG_CNT_ONE)
		else $error("data transmit counter missed an error");

	no_count_down_a: assert property ( // [R06]
		!clr_cnt |=> (st_q.ntx_cnt >= $past(st_q.ntx_cnt)) &&
			(st_q.drx_cnt >= $past(st_q.drx_cnt)))
		else $error("diagnostic counter went down");

	cnt_read_clear_a: assert property ( // [R07]
		(clr_cnt && !ev_any) |=> cnt_word == `CFDIAG_RESET_WORD)
		else $error("counter word not cleared by access");

	lenmm_sets_a: assert property ( // [R08]
		length_mismatch_i |=> st_q.flags[`CFDIAG_B_LENMM -
			`CFDIAG_FLAG_BASE])
		else $error("length mismatch flag not set");

	data_crc_phase_a: assert property ( // [R10]
		(crc_err_i && ph && !clr_flg) |=>
			st_q.flags[`CFDIAG_B_DCRC - `CFDIAG_FLAG_BASE] &&
			(st_q.flags[`CFDIAG_B_NCRC - `CFDIAG_FLAG_BASE] ==
			$past(st_q.flags[`CFDIAG_B_NCRC - `CFDIAG_FLAG_BASE])))
		else $error("crc error landed in the wrong phase flag");

	rsvd_zero_a: assert property ( // [R14]
		!st_q.flags[`CFDIAG_B_RSVD_HI - `CFDIAG_FLAG_BASE] &&
		!st_q.flags[`CFDIAG_B_RSVD_LO - `CFDIAG_FLAG_BASE])
		else $error("reserved flag bit set");

	flags_sticky_a: assert property ( // [R15]
		!clr_flg |=> (st_q.flags & $past(st_q.flags)) ==
			$past(st_q.flags))
		else $error("flag dropped without an access");

	flg_clear_a: assert property ( // [R16]
		(clr_flg && flag_set == `CFDIAG_RESET_WORD && !good_frame_i)
			|=> flg_word == `CFDIAG_RESET_WORD)
		else $error("flag word not cleared by access");

	good_count_a: assert property ( // [R18]
		(good_frame_i && !clr_flg &&
			st_q.good_cnt != `CFDIAG_GOOD_MAX) |=>
			st_q.good_cnt == $past(st_q.good_cnt) + `CFDIAG_GOOD_ONE)
		else $error("good frame counter missed a frame");

	recovery_flag_a: assert property ( // [R19]
		recovery_recessive_i |=>
			st_q.flags[`CFDIAG_B_NBIT0 - `CFDIAG_FLAG_BASE])
		else $error("recovery sequence not flagged");

	ack_flag_a: assert property ( // [R20]
		ack_err_i |=> st_q.flags[`CFDIAG_B_NACK - `CFDIAG_FLAG_BASE])
		else $error("missing acknowledge not flagged");

	set_beats_clear_a: assert property ( // [R21]
		(clr_cnt && ev_ntx) |=> st_q.ntx_cnt == `CFDIAG_CNT_ONE)
		else $error("error lost in clearing access");

	saturate_a: assert property ( // [R22]
		(st_q.nrx_cnt == `CFDIAG_CNT_MAX && !clr_cnt) |=>
			st_q.nrx_cnt == `CFDIAG_CNT_MAX)
		else $error("counter wrapped past maximum");

	rdata_one_cycle_a: assert property (
		!rd_i |=> rdata_o == `CFDIAG_RESET_WORD)
		else $error("read data outside its cycle");

	esi_sets_a: assert property ( // [R09]
		esi_rx_i |=> st_q.flags[`CFDIAG_B_ESI - `CFDIAG_FLAG_BASE])
		else $error("received error state flag not set");

	data_stuff_a: assert property ( // [R11]
		(stuff_err_i && ph) |=>
			st_q.flags[`CFDIAG_B_DSTUFF - `CFDIAG_FLAG_BASE])
		else $error("data stuffing error not flagged");

	data_form_a: assert property ( // [R12]
		(form_err_i && ph) |=>
			st_q.flags[`CFDIAG_B_DFORM - `CFDIAG_FLAG_BASE])
		else $error("data format error not flagged");

	data_bit1_a: assert property ( // [R13]
		(recessive_bit_err_i && ph) |=>
			st_q.flags[`CFDIAG_B_DBIT1 - `CFDIAG_FLAG_BASE])
		else $error("data recessive bit error not flagged");

	data_bit0_a: assert property ( // [R17]
		(dominant_bit_err_i && ph) |=>
			st_q.flags[`CFDIAG_B_DBIT0 - `CFDIAG_FLAG_BASE])
		else $error("data dominant bit error not flagged");

	nom_crc_phase_a: assert property ( // [R17]
		(crc_err_i && !ph && !clr_flg) |=>
			st_q.flags[`CFDIAG_B_NCRC - `CFDIAG_FLAG_BASE] &&
			(st_q.flags[`CFDIAG_B_DCRC - `CFDIAG_FLAG_BASE] ==
			$past(st_q.flags[`CFDIAG_B_DCRC - `CFDIAG_FLAG_BASE])))
		else $error("nominal crc error landed in the data flag");

	drx_increment_a: assert property ( // [R05]
		(ev_drx && !clr_cnt && st_q.drx_cnt != `CFDIAG_CNT_MAX) |=>
			st_q.drx_cnt == $past(st_q.drx_cnt) + `CFDIAG_CNT_ONE)
		else $error("data receive counter missed an error");

	ack_counts_a: assert property ( // [R05]
		(ack_err_i && !clr_cnt && st_q.ntx_cnt != `CFDIAG_CNT_MAX) |=>
			st_q.ntx_cnt == $past(st_q.ntx_cnt) + `CFDIAG_CNT_ONE)
		else $error("missing acknowledge not counted");

	dtx_nrx_monotonic_a: assert property ( // [R06]
		!clr_cnt |=> (st_q.dtx_cnt >= $past(st_q.dtx_cnt)) &&
			(st_q.nrx_cnt >= $past(st_q.nrx_cnt)))
		else $error("data tx or nominal rx counter went down");

	dtx_saturate_a: assert property ( // [R22]
		(st_q.dtx_cnt == `CFDIAG_CNT_MAX && !clr_cnt) |=>
			st_q.dtx_cnt == `CFDIAG_CNT_MAX)
		else $error("data transmit counter wrapped");

	good_clear_a: assert property ( // [R18]
		(clr_flg && !good_frame_i) |=> st_q.good_cnt == `CFDIAG_GOOD_ZERO)
		else $error("good frame counter not cleared");

	flg_read_layout_a: assert property ( // [R18]
		(rd_i && sel_flg) |=> rdata_o == {$past(st_q.flags),
			$past(st_q.good_cnt)})
		else $error("flag word read layout wrong");

	read_clear_c: cover property (
		(rd_i && sel_cnt && cnt_word != `CFDIAG_RESET_WORD));
	flag_collide_c: cover property (clr_flg && flag_set != '0);
	saturate_c: cover property (st_q.drx_cnt == `CFDIAG_CNT_MAX);
	passive_c: cover property (receiver_error_passive_flag_o);
	ack_receiving_c: cover property (ack_err_i && !err_tx_i);

endmodule : cfdiag_top

`default_nettype wire

// ### bench/cfdiag_engine_model.sv
// Purpose: protocol engine stand-in raising one error event per call
// Assumes: bench calls fire() one request at a time
// Notes: qualifiers flip between pulses so stale values never help
`default_nettype none

module cfdiag_engine_model (
	// clock
	input wire logic clock_i,
	// event pulses and qualifiers
	output logic [10:0] ev_o,
	output logic ph_o,
	output logic tx_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		ev_o = 11'h000;
		ph_o = 1'b0;
		tx_o = 1'b0;
	end

	// ------------------------------------------------------------
	// one-cycle pulse, qualifiers valid only in that cycle
	// ------------------------------------------------------------
	task automatic fire(input logic [10:0] ev, input logic ph,
		input logic tx);
		@(posedge clock_i);
		ev_o <= ev;
		ph_o <= ph;
		tx_o <= tx;
		@(posedge clock_i);
		ev_o <= 11'h000;
		ph_o <= ~ph;
		tx_o <= ~tx;
	endtask : fire
endmodule : cfdiag_engine_model

`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench of the bus diagnostics block
// Assumes: engine model drives the event pulses
// Notes: expected words are kept here and cleared at each access
`include "cfdiag_defines.svh"
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd, ph, tx, pas, wrn;
	logic [`CFDIAG_ADDR_W-1:0] addr;
	logic [`CFDIAG_DATA_W-1:0] wdata, rdata, e_cnt, e_flg;
	logic [10:0] ev;
	logic [7:0] cnt;
	int err_count, n_checks;
	int vals[7] = '{0, 95, 96, 127, 128, 255, 0};

	cfdiag_top cfdiag_top_inst (.clock_i(clk), .rst_i(rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.err_data_phase_i(ph), .err_tx_i(tx), .crc_err_i(ev[0]),
		.stuff_err_i(ev[1]), .form_err_i(ev[2]),
		.recessive_bit_err_i(ev[3]), .dominant_bit_err_i(ev[4]),
		.ack_err_i(ev[5]), .length_mismatch_i(ev[6]), .esi_rx_i(ev[7]),
		.bus_off_event_i(ev[8]), .recovery_recessive_i(ev[9]),
		.good_frame_i(ev[10]), .standard_receive_error_count_i(cnt),
		.receiver_error_passive_flag_o(pas),
		.receiver_warning_flag_o(wrn));
	cfdiag_engine_model cfdiag_engine_model_inst (.clock_i(clk),
		.ev_o(ev), .ph_o(ph), .tx_o(tx));

	always #10 clk = ~clk;

	// ------------------------------------------------------------
	// expectations
	// ------------------------------------------------------------
	function automatic logic [31:0] flag_of(int k, logic ph);
		case (k)
			0: flag_of = ph ? 32'h2000_0000 : 32'h0020_0000;
			1: flag_of = ph ? 32'h1000_0000 : 32'h0010_0000;
			2: flag_of = ph ? 32'h0800_0000 : 32'h0008_0000;
			3: flag_of = ph ? 32'h0200_0000 : 32'h0002_0000;
			4: flag_of = ph ? 32'h0100_0000 : 32'h0001_0000;
			5: flag_of = 32'h0004_0000;
			6: flag_of = 32'h8000_0000;
			7: flag_of = 32'h4000_0000;
			8: flag_of = 32'h0080_0000;
			9: flag_of = 32'h0001_0000;
			default: flag_of = 32'h0000_0000;
		endcase
	endfunction : flag_of

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic apply(int k, logic p, logic t);
		int l;
		l = (k == 5) ? 8 : (p ? 16 : 0) + (t ? 8 : 0);
		cfdiag_engine_model_inst.fire(11'h001 << k, p, t);
		e_flg = e_flg | flag_of(k, p);
		if (k < 6 && e_cnt[l +: 8] !== 8'hff) begin
			e_cnt[l +: 8] = e_cnt[l +: 8] + 8'h01;
		end
		if (k == 10 && e_flg[15:0] !== 16'hffff) begin
			e_flg[15:0] = e_flg[15:0] + 16'h0001;
		end
	endtask : apply

	// read clears expected on entry, before the strobe is raised; later events add again
	task automatic rd_word(logic [7:0] a);
		logic [31:0] e;
		e = (a == 8'h00) ? e_cnt : (a == 8'h04) ? e_flg : 32'h0;
		if (a == 8'h00) e_cnt = 32'h0;
		if (a == 8'h04) e_flg = 32'h0;
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("read word", e, rdata);
	endtask : rd_word

	task automatic wr_word(logic [7:0] a);
		if (a == 8'h00) e_cnt = 32'h0;
		if (a == 8'h04) e_flg = 32'h0;
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= $urandom;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_word

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{wr, rd, addr, wdata, cnt} = '0;
		{e_cnt, e_flg, err_count, n_checks} = '0;
		void'($urandom(31375));
		vals[6] = $urandom_range(0, 255);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd_word(8'h00);
		rd_word(8'h04);
		@(posedge clk);
		#1 chk("idle data", 32'h0, rdata);
		foreach (vals[i]) begin
			@(posedge clk);
			cnt <= vals[i][7:0];
			repeat (2) @(posedge clk);
			#1 chk("passive", 32'(vals[i] > 127), 32'(pas));
			chk("warning", 32'(vals[i] > 95 && vals[i] < 128), 32'(wrn));
		end
		repeat (3) begin
			repeat (40) apply($urandom_range(0, 10), 1'($urandom_range(0, 1)),
				1'($urandom_range(0, 1)));
			rd_word(8'h00);
			rd_word(8'h04);
			rd_word(8'h00);
			rd_word(8'h04);
		end
		for (int k = 0; k < 11; k++) begin
			for (int p = 0; p < 2; p++) begin
				apply(k, 1'(p), 1'($urandom_range(0, 1)));
				rd_word(8'h04);
				rd_word(8'h00);
			end
		end
		repeat (260) apply(0, 1'b0, 1'b0);
		rd_word(8'h00);
		fork
			apply(3, 1'b1, 1'b1);
			rd_word(8'h00);
		join
		rd_word(8'h00);
		fork
			apply(1, 1'b0, 1'b0);
			rd_word(8'h04);
		join
		rd_word(8'h04);
		apply(0, 1'b1, 1'b1);
		apply(2, 1'b0, 1'b1);
		apply(10, 1'b0, 1'b0);
		wr_word(8'h08);
		rd_word(8'h08);
		wr_word(8'h04);
		rd_word(8'h04);
		wr_word(8'h00);
		rd_word(8'h00);
		finish_test;
	end

	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		finish_test;
	end
endmodule : testbench

`default_nettype wire
